// ---- rtl/adc_mux_control_status.sv ----
// Control, selection and result logic of the successive-approximation converter.
// Behaviour
// RL1 - Bits 7:6 pick reference: 00 pin, 01 analog supply, 11 internal, 10 reserved.
// RL2 - Reference or channel writes during a conversion apply only after it completes.
// RL3 - Left-adjust bit one left-justifies the result, zero right-justifies it.
// RL4 - Changing left-adjust alters the presented result immediately, even mid-conversion.
// RL5 - Channel codes 0 to 7 select single-ended inputs 0 to 7.
// RL6 - Codes 8 to 29 select a differential pair and gain per fixed table.
// RL7 - Code 30 routes the bandgap, code 31 routes ground.
// RL8 - Enable bit powers the converter; clearing it aborts a running conversion.
// RL9 - Writing start begins a conversion; free-running mode needs only the first.
// RL10 - First conversion after enabling takes 25 converter clocks, later ones 13.
// RL11 - Start bit reads one while converting; writing zero does nothing.
// RL12 - Auto-trigger starts a conversion on each rising edge of the chosen trigger.
// RL13 - Done flag sets when a conversion completes and the result is stored.
// RL14 - Interrupt asserts while done, interrupt enable and global enable are set.
// RL15 - Done flag clears on interrupt vectoring or on writing one to it.
// RL16 - Software avoids read-modify-write of control, which would clear done.
// RL17 - Divider code 0 and 1 divide by 2, then 4 up to 128.
// RL18 - Trigger code zero is free-running; switching to it makes no trigger.
// RL19 - Reading the low result byte freezes the result until the high byte read.
// RL20 - Differential results are ten-bit two's complement from 0x200 to 0x1ff.
// RL21 - Core result is sampled when the count ends; result and done update then.
// RL22 - A start written during a conversion neither restarts nor extends it.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_ctrl_map.svh"
module adc_mux_control_status (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [4:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [4:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [6:0]             trigger_flags,
  input  wire logic                   global_irq_enable,
  input  wire logic                   irq_vector_ack,
  input  wire logic [9:0]             core_result,
  output logic                        core_enable,
  output logic                        core_clock_tick,
  output logic                        core_busy,
  output logic                        core_init,
  output logic [1:0]                  active_reference,
  output logic                        internal_reference_on,
  output adc_ctrl_pkg::mux_route_type active_route,
  output logic                        conv_irq
);
  import adc_ctrl_pkg::*;

  // ==========================================================================
  // Bus slave state.
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [4:0]  aw_addr, next_aw_addr;
  logic [7:0]  w_byte, next_w_byte;
  logic        w_lane0, next_w_lane0;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        wr_fire, rd_fire;
  logic        wr_select, wr_control, wr_trigger;

  // Converter state.
  input_select_type   sel, next_sel;
  control_status_type ctl, next_ctl;
  logic [2:0]         trig_src, next_trig_src;
  conv_state_type     state, next_state;
  logic [4:0]         cycle_count, next_cycle_count;
  logic               first_pending, next_first_pending;
  logic               conv_first, next_conv_first;
  logic [1:0]         act_ref, next_act_ref;
  logic [4:0]         act_channel, next_act_channel;
  logic [9:0]         result_raw, next_result_raw;
  logic               result_locked, next_result_locked;
  logic               prev_trigger, next_prev_trigger;
  logic               tick, done_now, sw_start, auto_start, start_now;
  logic               enable_next, trigger_level, trigger_edge;
  logic [4:0]         conv_last;
  logic [7:0]         result_low, result_high;

  // ==========================================================================
  // Submodules.
  adc_clock_divider #(.COUNT_WIDTH(7)) u_divider (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .run            (ctl.converter_enable),
    .divider_select (ctl.clock_divider_select),
    .tick           (tick)
  );

  adc_channel_decoder u_decoder (
    .channel_gain_select (act_channel),
    .route               (active_route)
  );

  // ==========================================================================
  // Write and read handshakes; address and data are taken in either order.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign wr_fire    = aw_held && w_held && !bvalid;
  assign rd_fire    = s_axi_arvalid && !rvalid;
  assign wr_select  = wr_fire && w_lane0 && (aw_addr == `OFS_INPUT_SELECT);
  assign wr_control = wr_fire && w_lane0 && (aw_addr == `OFS_CONTROL);
  assign wr_trigger = wr_fire && w_lane0 && (aw_addr == `OFS_TRIGGER);

  // Result presentation follows the live left-adjust bit, not a stored copy.
  always_comb begin
    if (sel.left_adjust) begin
      result_low  = {result_raw[1:0], 6'h00}; // RL3 RL4
      result_high = result_raw[9:2];
    end else begin
      result_low  = result_raw[7:0]; // RL3 RL4
      result_high = {6'h00, result_raw[9:8]};
    end
  end

  // Bus channel next values, including read data and the unmapped answer.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held  = 1'b1;
      next_w_byte  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      unique case (aw_addr)
        `OFS_INPUT_SELECT, `OFS_CONTROL, `OFS_TRIGGER, `OFS_RESULT_LOW,
        `OFS_RESULT_HIGH: next_bresp = `RESP_OKAY;
        default:          next_bresp = `RESP_SLVERR;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `OFS_INPUT_SELECT: next_rdata[7:0] = sel;
        `OFS_CONTROL:      next_rdata[7:0] = ctl;
        `OFS_RESULT_LOW:   next_rdata[7:0] = result_low;
        `OFS_RESULT_HIGH:  next_rdata[7:0] = result_high;
        `OFS_TRIGGER:      next_rdata[7:5] = trig_src;
        default:           next_rresp      = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 5'h00;
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `RESP_OKAY;
      rdata   <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_byte  <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  // ==========================================================================
  // Start sources. A start is only honoured when idle or finishing, so a
  // repeated start never stretches the conversion in flight.
  assign enable_next   = wr_control ? w_byte[7] : ctl.converter_enable;
  assign conv_last     = conv_first ? 5'(`FIRST_CONV_CYCLES - 5'h01) : 5'(`NORMAL_CONV_CYCLES - 5'h01);
  assign done_now      = (state == CONV_BUSY) && tick && (cycle_count == conv_last); // RL21
  assign trigger_level = (trig_src == `TRIGGER_FREE_RUN) ? 1'b0 : trigger_flags[trig_src - 3'h1];
  // Free-running code forces the edge off, so selecting it never fires.
  assign trigger_edge  = trigger_level && !prev_trigger && (trig_src != `TRIGGER_FREE_RUN); // RL18
  assign sw_start      = wr_control && w_byte[6] && w_byte[7]; // RL9 RL11
  assign auto_start    = ctl.auto_trigger_enable &&
                         ((trig_src == `TRIGGER_FREE_RUN) ? done_now : trigger_edge); // RL12
  assign start_now     = (sw_start || auto_start) && enable_next &&
                         ((state == CONV_IDLE) || done_now); // RL22

  // Register, sequencer and result next values.
  always_comb begin
    next_sel           = sel;
    next_ctl           = ctl;
    next_trig_src      = trig_src;
    next_state         = state;
    next_cycle_count   = cycle_count;
    next_first_pending = first_pending;
    next_conv_first    = conv_first;
    next_act_ref       = act_ref;
    next_act_channel   = act_channel;
    next_result_raw    = result_raw;
    next_result_locked = result_locked;
    next_prev_trigger  = trigger_level;
    if (wr_select) begin
      next_sel = w_byte;
    end
    if (wr_trigger) begin
      next_trig_src = w_byte[7:5];
    end
    if (wr_control) begin
      next_ctl.converter_enable     = w_byte[7]; // RL8
      next_ctl.auto_trigger_enable  = w_byte[5];
      next_ctl.done_irq_enable      = w_byte[3];
      next_ctl.clock_divider_select = w_byte[2:0];
    end
    // Clear by writing one or by vectoring; a completion in the same cycle wins.
    if ((wr_control && w_byte[4]) || irq_vector_ack) begin
      next_ctl.conversion_done_flag = 1'b0; // RL15
    end
    if (state == CONV_BUSY && tick) begin
      next_cycle_count = 5'(cycle_count + 5'h01);
    end
    if (done_now) begin
      next_state = CONV_IDLE;
      next_ctl.conversion_done_flag = 1'b1; // RL13
      if (!result_locked) begin
        next_result_raw = core_result; // RL21 RL20
      end
    end
    // Selections are copied only between conversions.
    if (state == CONV_IDLE || done_now) begin
      next_act_ref     = sel.reference_select; // RL2 RL1
      next_act_channel = sel.channel_gain_select;
    end
    if (start_now) begin
      next_state         = CONV_BUSY;
      next_cycle_count   = 5'h00;
      next_conv_first    = first_pending; // RL10
      next_first_pending = 1'b0;
    end
    if (!enable_next) begin
      next_state         = CONV_IDLE; // RL8
      next_first_pending = 1'b1; // RL10
    end
    next_ctl.conversion_start_bit = (next_state == CONV_BUSY); // RL11
    if (rd_fire && s_axi_araddr == `OFS_RESULT_LOW) begin
      next_result_locked = 1'b1; // RL19
    end
    if (rd_fire && s_axi_araddr == `OFS_RESULT_HIGH) begin
      next_result_locked = 1'b0; // RL19
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel           <= `RESET_SELECT;
      ctl           <= `RESET_CONTROL;
      trig_src      <= `RESET_TRIGGER;
      state         <= CONV_IDLE;
      cycle_count   <= 5'h00;
      first_pending <= 1'b1;
      conv_first    <= 1'b0;
      act_ref       <= 2'h0;
      act_channel   <= 5'h00;
      result_raw    <= `RESET_RESULT;
      result_locked <= 1'b0;
      prev_trigger  <= 1'b0;
    end else begin
      sel           <= next_sel;
      ctl           <= next_ctl;
      trig_src      <= next_trig_src;
      state         <= next_state;
      cycle_count   <= next_cycle_count;
      first_pending <= next_first_pending;
      conv_first    <= next_conv_first;
      act_ref       <= next_act_ref;
      act_channel   <= next_act_channel;
      result_raw    <= next_result_raw;
      result_locked <= next_result_locked;
      prev_trigger  <= next_prev_trigger;
    end
  end

  // ==========================================================================
  // Core-facing outputs. Reserved reference code 10 is passed through; the
  // internal reference is powered only for code 11.
  assign core_enable           = ctl.converter_enable; // RL8
  assign core_clock_tick       = tick;
  assign core_busy             = (state == CONV_BUSY);
  assign core_init             = (state == CONV_BUSY) && conv_first;
  assign active_reference      = act_ref; // RL1
  assign internal_reference_on = (act_ref == 2'b11); // RL1
  assign conv_irq = ctl.conversion_done_flag && ctl.done_irq_enable && global_irq_enable; // RL14

  // ==========================================================================
  // Checks on the sequencer and result path.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  selection_hold_a: assert property ((state == CONV_BUSY) && !done_now |=> // RL2
    $stable(act_ref) && $stable(act_channel)) else $error("Selection moved mid-conversion.");
  done_sets_a: assert property (done_now |=> ctl.conversion_done_flag && // RL13
    core_busy == $past(start_now)) else $error("Done flag not set at completion.");
  result_sample_a: assert property (done_now && !result_locked |=> // RL21
    result_raw == $past(core_result)) else $error("Result not sampled at completion.");
  result_lock_a: assert property (done_now && result_locked |=> $stable(result_raw)) // RL19
    else $error("Locked result was overwritten.");
  abort_conv_a: assert property (wr_control && !w_byte[7] |=> !core_busy && !core_enable) // RL8
    else $error("Disable did not abort the conversion.");
  start_ignore_a: assert property ((state == CONV_BUSY) && !done_now && !tick && sw_start // RL22
    |=> cycle_count == $past(cycle_count) && core_busy) else $error("Busy start restarted.");
  irq_raise_a: assert property ($rose(ctl.conversion_done_flag) && ctl.done_irq_enable // RL14
    && global_irq_enable |-> conv_irq) else $error("Interrupt missing after done.");
  vector_clear_a: assert property (irq_vector_ack && !done_now |=> // RL15
    !ctl.conversion_done_flag) else $error("Done flag survived vectoring.");
  first_length_a: assert property (start_now && first_pending |=> conv_last == // RL10
    5'(`FIRST_CONV_CYCLES - 5'h01)) else $error("First conversion not 25 cycles.");
  free_switch_a: assert property (wr_trigger && w_byte[7:5] == `TRIGGER_FREE_RUN // RL18
    |=> !trigger_edge) else $error("Switch to free-running made a trigger.");

  first_conv_c: cover property (done_now && conv_first);
  free_run_c: cover property (done_now && auto_start);
  abort_c: cover property (core_busy && wr_control && !w_byte[7]);
  lock_c: cover property (done_now && result_locked);

endmodule : adc_mux_control_status

// ---- rtl/adc_ctrl_map.svh ----
// Register offsets, reset values and conversion lengths of the converter control block.
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// ==========================================================================
// Register byte offsets on the register bus.
`define OFS_INPUT_SELECT  5'h00
`define OFS_CONTROL       5'h04
`define OFS_RESULT_LOW    5'h08
`define OFS_RESULT_HIGH   5'h0c
`define OFS_TRIGGER       5'h10

// ==========================================================================
// Reset values of the software registers.
`define RESET_SELECT      8'h00
`define RESET_CONTROL     8'h00
`define RESET_TRIGGER     3'h0
`define RESET_RESULT      10'h000

// ==========================================================================
// Conversion lengths in converter clock cycles.
`define FIRST_CONV_CYCLES  5'h19
`define NORMAL_CONV_CYCLES 5'h0d

// ==========================================================================
// Bus response codes, trigger codes and divider codes.
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`define TRIGGER_FREE_RUN  3'h0
`define DIVIDE_BY_TWO_MAX 3'h1

`endif

// ---- rtl/adc_ctrl_pkg.sv ----
// Types shared by the converter control block and its submodules.
package adc_ctrl_pkg;

  // ========================================================================
  // Software register layouts.
  typedef struct packed {
    logic [1:0] reference_select;
    logic       left_adjust;
    logic [4:0] channel_gain_select;
  } input_select_type;

  typedef struct packed {
    logic       converter_enable;
    logic       conversion_start_bit;
    logic       auto_trigger_enable;
    logic       conversion_done_flag;
    logic       done_irq_enable;
    logic [2:0] clock_divider_select;
  } control_status_type;

  // ========================================================================
  // Analog routing handed to the converter core.
  typedef enum logic [1:0] {
    KIND_SINGLE  = 2'b00,
    KIND_DIFF    = 2'b01,
    KIND_BANDGAP = 2'b10,
    KIND_GROUND  = 2'b11
  } input_kind_type;

  typedef enum logic [1:0] {
    GAIN_1X   = 2'b00,
    GAIN_10X  = 2'b01,
    GAIN_200X = 2'b10
  } gain_type;

  typedef struct packed {
    input_kind_type kind;
    logic [2:0]     positive_input;
    logic [1:0]     negative_input;
    gain_type       gain;
  } mux_route_type;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_type;

endpackage : adc_ctrl_pkg

// ---- rtl/adc_clock_divider.sv ----
// Divider that turns the system clock into converter clock enable pulses.
`timescale 1ns/100ps
module adc_clock_divider #(
  parameter int COUNT_WIDTH = 7
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] divider_select,
  output logic            tick
);
  import adc_ctrl_pkg::*;

  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH-1:0] next_count;
  logic [COUNT_WIDTH:0]   factor;
  logic [COUNT_WIDTH-1:0] limit;

  // ==========================================================================
  // Codes 0 and 1 both divide by two, the rest by a power of two.
  always_comb begin
    factor = (divider_select <= 3'h1) ? (COUNT_WIDTH+1)'(2) : (COUNT_WIDTH+1)'(1) << divider_select;
    limit = COUNT_WIDTH'(factor - 1'b1); // RL17
    tick = run && (count == limit);
    next_count = (!run || tick) ? '0 : COUNT_WIDTH'(count + 1'b1);
  end

  // Held at zero while stopped, so the first conversion after enabling starts on a clean phase.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : adc_clock_divider

// ---- rtl/adc_channel_decoder.sv ----
// Decoder from the channel and gain code to the analog routing.
`timescale 1ns/100ps
module adc_channel_decoder (
  input  wire logic [4:0]               channel_gain_select,
  output adc_ctrl_pkg::mux_route_type   route
);
  import adc_ctrl_pkg::*;

  // ==========================================================================
  // The differential table is regular enough to decode field by field.
  always_comb begin
    route = '{kind: KIND_SINGLE, positive_input: 3'h0, negative_input: 2'h0, gain: GAIN_1X};
    unique casez (channel_gain_select)
      5'b00???: begin
        route.positive_input = channel_gain_select[2:0]; // RL5
      end
      5'b01???: begin
        route.kind = KIND_DIFF; // RL6
        route.positive_input = {1'b0, channel_gain_select[2], channel_gain_select[0]};
        route.negative_input = channel_gain_select[2] ? 2'h2 : 2'h0;
        route.gain = channel_gain_select[1] ? GAIN_200X : GAIN_10X;
      end
      5'b10???: begin
        route.kind = KIND_DIFF; // RL6
        route.positive_input = channel_gain_select[2:0];
        route.negative_input = 2'h1;
      end
      5'b11110: begin
        route.kind = KIND_BANDGAP; // RL7
      end
      5'b11111: begin
        route.kind = KIND_GROUND; // RL7
      end
      default: begin
        route.kind = KIND_DIFF; // RL6
        route.positive_input = channel_gain_select[2:0];
        route.negative_input = 2'h2;
      end
    endcase
  end

endmodule : adc_channel_decoder

// ---- tb/core_model.sv ----
// Behavioural converter core that hands its result to the control block.
`timescale 1ns/100ps
module core_model (
  input  wire logic       core_busy,
  input  wire logic [9:0] level,
  output logic [9:0]      core_result
);
  // Outside a conversion the lines show the inverse, so a stray sample is caught.
  assign core_result = core_busy ? level : ~level;
endmodule : core_model

// ---- tb/testbench.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
module testbench;
  import adc_ctrl_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic global_irq_enable, irq_vector_ack, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, core_enable, core_clock_tick, core_busy, core_init;
  logic internal_reference_on, conv_irq;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, active_reference, resp;
  logic [6:0] trigger_flags;
  logic [9:0] core_result, level;
  mux_route_type active_route;
  int n_mismatch, checks, ticks, cycles;

  adc_mux_control_status i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trigger_flags, .global_irq_enable, .irq_vector_ack,
    .core_result, .core_enable, .core_clock_tick, .core_busy, .core_init, .active_reference,
    .internal_reference_on, .active_route, .conv_irq);
  core_model i_core (.core_busy, .level, .core_result);

  // ==========================================================================
  // Clock, tick counting and hang guard.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Ticks are counted at the falling edge, where the design outputs have settled.
  always @(negedge aclk) begin
    cycles++;
    if (core_busy && core_clock_tick) ticks++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One register access; readies are sampled at the falling edge before each taking edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    logic fin, ta, tw, tr;
    fin = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (!fin) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_arready;
      fin = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      resp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (fin) {s_axi_bready, s_axi_rready} <= 2'b00;
    end
    @(negedge aclk);
  endtask : bus

  task automatic idle();
    do @(negedge aclk); while (core_busy);
  endtask : idle

  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    bus(0, 5'h04, 8'h00);
    check("control reset", q, 32'h0);
    bus(1, 5'h14, 8'hff);
    check("unmapped write", resp, 2'b10);
    bus(0, 5'h14, 8'h00);
    check("unmapped read", {resp, q[29:0]}, 32'h80000000);
  endtask : t_regs

  // Route fields are masked where a code leaves them undefined.
  task automatic t_route();
    logic [7:0] cd [6] = '{8'hc9, 8'h4b, 8'h1d, 8'h07, 8'h1e, 8'h1f};
    logic [8:0] ex [6] = '{9'h091, 9'h092, 9'h0d8, 9'h070, 9'h100, 9'h180};
    logic [8:0] mk [6] = '{9'h1ff, 9'h1ff, 9'h1ff, 9'h1f0, 9'h180, 9'h180};
    foreach (cd[i]) begin
      bus(1, 5'h00, cd[i]);
      check("route", active_route & mk[i], ex[i]);
      check("reference", active_reference, cd[i][7:6]);
      check("internal ref", internal_reference_on, cd[i][7:6] == 2'b11);
    end
  endtask : t_route

  task automatic t_conv();
    level = 10'h270;
    bus(1, 5'h00, 8'h00);
    ticks = 0;
    bus(1, 5'h04, 8'hc0);
    check("init", core_init, 1'b1);
    idle();
    check("first ticks", ticks, 25);
    bus(0, 5'h04, 8'h00);
    check("status", q, 32'h90);
    bus(1, 5'h04, 8'h90);
    bus(0, 5'h04, 8'h00);
    check("done w1c", q, 32'h80);
    bus(0, 5'h08, 8'h00);
    check("low right", q, 32'h70);
    bus(0, 5'h0c, 8'h00);
    check("high right", q, 32'h02);
    level = 10'h1ff;
    ticks = 0;
    bus(1, 5'h04, 8'hc0);
    bus(0, 5'h04, 8'h00);
    check("start busy", q[6], 1'b1);
    bus(1, 5'h04, 8'hc0);
    bus(1, 5'h00, 8'h3f);
    check("route held", active_route.kind, KIND_SINGLE);
    bus(0, 5'h0c, 8'h00);
    check("high left busy", q, 32'h9c);
    idle();
    check("ticks", ticks, 13);
    check("route applied", active_route.kind, KIND_GROUND);
    bus(0, 5'h08, 8'h00);
    check("low left", q, 32'hc0);
    bus(0, 5'h0c, 8'h00);
    check("high left", q, 32'h7f);
  endtask : t_conv

  // Writing zero to the done bit keeps it, so the request must appear.
  task automatic t_irq();
    @(posedge aclk);
    global_irq_enable <= 1'b1;
    bus(1, 5'h04, 8'h88);
    check("irq on", conv_irq, 1'b1);
    @(posedge aclk);
    global_irq_enable <= 1'b0;
    @(negedge aclk);
    check("irq masked", conv_irq, 1'b0);
    @(posedge aclk);
    global_irq_enable <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge aclk);
    irq_vector_ack <= 1'b0;
    @(negedge aclk);
    check("irq cleared", conv_irq, 1'b0);
    bus(0, 5'h04, 8'h00);
    check("done cleared", q, 32'h88);
  endtask : t_irq

  task automatic t_auto();
    bus(1, 5'h10, 8'h20);
    bus(1, 5'h04, 8'ha0);
    @(posedge aclk);
    trigger_flags <= 7'h01;
    repeat (3) @(negedge aclk);
    check("triggered", core_busy, 1'b1);
    bus(1, 5'h04, 8'h00);
    check("aborted", {core_busy, core_enable}, 2'b00);
    bus(1, 5'h04, 8'ha0);
    bus(1, 5'h10, 8'h00);
    check("no free trigger", core_busy, 1'b0);
  endtask : t_auto

  // ==========================================================================
  // Main sequence.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
    {global_irq_enable, irq_vector_ack, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {trigger_flags, level, n_mismatch, checks, ticks, cycles} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_route();
    t_conv();
    t_irq();
    t_auto();
    close_out();
  end
endmodule : testbench
